/* src/pcp_cfg_regs.v */
// interrupt-select and power-management capability configuration registers
//
// How it works
// - hard reset loads 340B0100 into the interrupt-select register at 3C and soft reset leaves it alone.
// - bits 31-24 hold the maximum latency, starting at 52 decimal.
// - bits 23-16 hold the minimum grant, starting at 11 decimal.
// - the serial EEPROM autoload may overwrite maximum latency and minimum grant.
// - bits 15-8 are read-only and always return 01, naming the A interrupt pin.
// - the capability register at 40 is read-only, resets to FF820001 and ignores soft reset.
// - the capability register reads back only while command/status bit 4 is set.
// - bits 31-27 carry one wake-allowed bit per power state, D0 at bit 27 up to D3cold at 31.
// - D3cold wake is reported only with aux power sensed, and may be loaded from EEPROM in D3cold.
// - bit 26 reads 1 because D2 is supported.
// - bit 25 reads 1 because D1 is supported.
// - bits 24-22 give the aux current, 110 for 320 mA and 000 for self powered.
`timescale 1ns/1ps
`include "pcp_cfg_defs.vh"

module pcp_cfg_regs (
   clk,
   rst_n,
   soft_rst,
   cfg_rd,
   cfg_wr,
   cfg_addr,
   cfg_be,
   cfg_wdata,
   cfg_rdata,
   cfg_ack,
   cfg_hit,
   ee_lat_load,
   ee_max_lat,
   ee_min_gnt,
   ee_wake_load,
   ee_wake_d3cold,
   pm_state_d3cold,
   aux_supply_sense_pin,
   cap_list_enable,
   interrupt_line_field,
   max_latency_field,
   min_grant_field,
   wake_support_states
);
   input wire clk;
   input wire rst_n;
   input wire soft_rst;
   input wire cfg_rd;
   input wire cfg_wr;
   input wire [7:0] cfg_addr;
   input wire [3:0] cfg_be;
   input wire [31:0] cfg_wdata;
   output reg [31:0] cfg_rdata;
   output reg cfg_ack;
   output reg cfg_hit;
   input wire ee_lat_load;
   input wire [7:0] ee_max_lat;
   input wire [7:0] ee_min_gnt;
   input wire ee_wake_load;
   input wire ee_wake_d3cold;
   input wire pm_state_d3cold;
   input wire aux_supply_sense_pin;
   input wire cap_list_enable;
   output reg [7:0] interrupt_line_field;
   output reg [7:0] max_latency_field;
   output reg [7:0] min_grant_field;
   output reg [4:0] wake_support_states;

   // storage; soft_rst is deliberately not used by any of it
   reg [7:0] int_line_q;
   reg [7:0] int_line_d;
   reg [7:0] max_lat_q;
   reg [7:0] max_lat_d;
   reg [7:0] min_gnt_q;
   reg [7:0] min_gnt_d;
   reg d3cold_wake_q;
   reg d3cold_wake_d;
   reg [31:0] rdata_d;
   reg hit_d;
   wire [31:0] cap_word;
   wire sel_int;
   wire sel_cap;
   wire unused_soft;
   // full-width copies so the word-index compare needs no silent trim
   localparam [7:0] OFS_INT = `PCP_OFS_INT_SEL;
   localparam [7:0] OFS_CAP = `PCP_OFS_PM_CAP;

   function [31:0] int_sel_word;
      input [7:0] lat;
      input [7:0] gnt;
      input [7:0] line;
      begin
         int_sel_word = {lat, gnt, `PCP_INT_PIN_VALUE, line};
      end
   endfunction

   // only the two aligned words of this block decode; other offsets miss
   assign sel_int = (cfg_addr[7:2] == OFS_INT[7:2]);
   assign sel_cap = (cfg_addr[7:2] == OFS_CAP[7:2]);
   assign unused_soft = soft_rst;

   pcp_cap_word u_cap_word (
      .d3cold_wake_q(d3cold_wake_q),
      .aux_present(aux_supply_sense_pin),
      .cap_word(cap_word)
   );

   // interrupt-select register next values
   always @* begin
      int_line_d = int_line_q;
      max_lat_d = max_lat_q;
      min_gnt_d = min_gnt_q;
      if (cfg_wr && sel_int && cfg_be[0]) begin
         int_line_d = cfg_wdata[`PCP_INT_LINE_MSB:`PCP_INT_LINE_LSB];
      end
      // host writes to the latency and grant bytes are ignored: they
      // advertise the device's own needs and are not host settings
      if (ee_lat_load) begin
         max_lat_d = ee_max_lat;
         min_gnt_d = ee_min_gnt;
      end
   end

   // stored D3cold wake support; the load only counts while in D3cold
   always @* begin
      d3cold_wake_d = d3cold_wake_q;
      if (ee_wake_load && pm_state_d3cold) begin
         d3cold_wake_d = ee_wake_d3cold;
      end
   end

   // read path, answered one cycle after the strobe
   always @* begin
      rdata_d = 32'h00000000;
      hit_d = 1'b0;
      if (cfg_rd && sel_int) begin
         rdata_d = int_sel_word(max_lat_q, min_gnt_q, int_line_q);
         hit_d = 1'b1;
      end else if (cfg_rd && sel_cap && cap_list_enable) begin
         rdata_d = cap_word;
         hit_d = 1'b1;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_line_q <= `PCP_INT_LINE_RESET;
         max_lat_q <= `PCP_MAX_LAT_RESET;
         min_gnt_q <= `PCP_MIN_GNT_RESET;
         d3cold_wake_q <= 1'b1;
         cfg_rdata <= 32'h00000000;
         cfg_ack <= 1'b0;
         cfg_hit <= 1'b0;
         interrupt_line_field <= `PCP_INT_LINE_RESET;
         max_latency_field <= `PCP_MAX_LAT_RESET;
         min_grant_field <= `PCP_MIN_GNT_RESET;
         wake_support_states <= 5'h1F;
      end else begin
         int_line_q <= int_line_d;
         max_lat_q <= max_lat_d;
         min_gnt_q <= min_gnt_d;
         d3cold_wake_q <= d3cold_wake_d;
         cfg_rdata <= rdata_d;
         cfg_ack <= cfg_rd | cfg_wr;
         cfg_hit <= hit_d | (cfg_wr & (sel_int | sel_cap));
         interrupt_line_field <= int_line_d;
         max_latency_field <= max_lat_d;
         min_grant_field <= min_gnt_d;
         // mirrors the live capability field, lagging the sense pin by one
         wake_support_states <= cap_word[`PCP_WAKE_MSB:`PCP_WAKE_LSB];
      end
   end
endmodule // pcp_cfg_regs

/* src/pcp_cfg_defs.vh */
// constants for the interrupt-select and power-management capability block
`ifndef PCP_CFG_DEFS_VH
`define PCP_CFG_DEFS_VH

// configuration offsets (byte addresses)
`define PCP_OFS_INT_SEL 8'h3C
`define PCP_OFS_PM_CAP 8'h40

// interrupt_select_latency_grant layout and reset
`define PCP_INT_SEL_RESET 32'h340B0100
`define PCP_MAX_LAT_MSB 31
`define PCP_MAX_LAT_LSB 24
`define PCP_MIN_GNT_MSB 23
`define PCP_MIN_GNT_LSB 16
`define PCP_INT_PIN_MSB 15
`define PCP_INT_PIN_LSB 8
`define PCP_INT_LINE_MSB 7
`define PCP_INT_LINE_LSB 0
`define PCP_MAX_LAT_RESET 8'h34
`define PCP_MIN_GNT_RESET 8'h0B
`define PCP_INT_PIN_VALUE 8'h01
`define PCP_INT_LINE_RESET 8'h00

// power_mgmt_capabilities layout and reset
`define PCP_PM_CAP_RESET 32'hFF820001
`define PCP_WAKE_MSB 31
`define PCP_WAKE_LSB 27
`define PCP_WAKE_D3COLD 31
`define PCP_D2_BIT 26
`define PCP_D1_BIT 25
`define PCP_AUX_MSB 24
`define PCP_AUX_LSB 22
`define PCP_LOW_MSB 21
`define PCP_AUX_NONE 3'h0

`endif

/* src/pcp_cap_word.v */
// builds the read value of the power-management capability register
`timescale 1ns/1ps
`include "pcp_cfg_defs.vh"

module pcp_cap_word (
   d3cold_wake_q,
   aux_present,
   cap_word
);
   input wire d3cold_wake_q;
   input wire aux_present;
   output reg [31:0] cap_word;

   reg [31:0] base;
   reg wake_cold;

   always @* begin
      base = `PCP_PM_CAP_RESET;
      // cold wake needs both the stored support and a live aux supply
      wake_cold = d3cold_wake_q & aux_present;
      cap_word = base;
      cap_word[`PCP_WAKE_D3COLD] = wake_cold;
      if (!wake_cold) begin
         cap_word[`PCP_AUX_MSB:`PCP_AUX_LSB] = `PCP_AUX_NONE;
      end
   end
endmodule // pcp_cap_word

/* testbench/pcp_sva.sv */
// assertions on the config register ports
`timescale 1ns/1ps
module pcp_sva (
   input logic clk,
   input logic rst_n,
   input logic cfg_rd,
   input logic [7:0] cfg_addr,
   input logic [31:0] cfg_rdata,
   input logic cfg_hit,
   input logic cap_list_enable,
   input logic aux_supply_sense_pin,
   input logic [4:0] wake_support_states,
   input logic [7:0] interrupt_line_field,
   input logic [7:0] max_latency_field,
   input logic [7:0] min_grant_field
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_int; cfg_rd && cfg_addr[7:2] == 6'h0F; endsequence
   sequence s_cap; cfg_rd && cfg_addr[7:2] == 6'h10; endsequence
   a_line_reset:
      assert property ($rose(rst_n) |-> interrupt_line_field == 8'h00)
      else $error("line");
   a_pin_const:
      assert property (s_int |=> cfg_hit && cfg_rdata[15:8] == 8'h01)
      else $error("pin");
   a_line_back:
      assert property (s_int |=> cfg_rdata[7:0] == interrupt_line_field)
      else $error("line back");
   a_cap_hidden:
      assert property (s_cap ##0 !cap_list_enable |=> !cfg_hit && !cfg_rdata)
      else $error("hidden");
   a_cap_fixed:
      assert property (s_cap ##0 cap_list_enable |=> cfg_hit &&
         cfg_rdata[30:25] == 6'h3F && cfg_rdata[21:0] == 22'h020001)
      else $error("cap");
   a_aux_code:
      assert property (s_cap ##0 cap_list_enable |=>
         cfg_rdata[24:22] == {cfg_rdata[31], cfg_rdata[31], 1'b0})
      else $error("aux");
   a_cold_aux:
      assert property (s_cap ##0 !aux_supply_sense_pin |=> !cfg_rdata[31])
      else $error("cold");
   a_lat_mirror:
      assert property (s_int |=>
         cfg_rdata[31:16] == {max_latency_field, min_grant_field})
      else $error("latency mirror");
   a_wake_lag:
      assert property (!aux_supply_sense_pin |=> wake_support_states == 5'h0F)
      else $error("wake");
endmodule // pcp_sva

/* testbench/pcp_host.sv */
// host model issuing one-cycle config accesses
`timescale 1ns/1ps
module pcp_host (
   input logic clk,
   output logic cfg_rd = 1'b0,
   output logic cfg_wr = 1'b0,
   output logic [7:0] cfg_addr = 8'h00,
   output logic [3:0] cfg_be = 4'h0,
   output logic [31:0] cfg_wdata = 32'h0
);
   // released data is inverted so a stale value never passes
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {cfg_rd, cfg_wr, cfg_addr, cfg_be} <= {!w, w, a, 4'hF};
      cfg_wdata <= d;
      @(posedge clk);
      {cfg_rd, cfg_wr, cfg_wdata} <= {2'h0, ~d};
   endtask
endmodule // pcp_host

/* testbench/pci_cfg_int_pm_capability_tb.sv */
// bench for the interrupt-select and capability registers
`timescale 1ns/1ps
module pci_cfg_int_pm_capability_tb;
   logic clk = 0, rst_n = 0, soft_rst = 0, cfg_rd, cfg_wr, cfg_ack, cfg_hit;
   logic ee_lat_load = 0, ee_wake_load = 0, ee_wake_d3cold = 0, b, wk;
   logic pm_state_d3cold = 0, aux_supply_sense_pin = 1, cap_list_enable = 0;
   logic [7:0] cfg_addr, ee_max_lat = 0, ee_min_gnt = 0, lat, gnt, ln;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, x;
   logic [32:0] q[$];
   integer seed = 83982, err_total = 0, tests_run = 0, i;
   always #5 clk = ~clk;
   pcp_host host (.*);
   pcp_cfg_regs DUT (.*, .interrupt_line_field(), .max_latency_field(),
      .min_grant_field(), .wake_support_states());
   task chk(input logic [32:0] s, e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %0t %h %h", $time, s, e);
      end
   endtask
   task op(input logic w, input logic [7:0] a, input logic [31:0] d);
      b = wk & aux_supply_sense_pin;
      x = 32'h0;
      if (!w && a == 8'h3C) x = {lat, gnt, 8'h01, ln};
      if (!w && a == 8'h40 && cap_list_enable)
         x = {b, 6'h3F, b, b, 23'h020001};
      if (w && a == 8'h3C) ln = d[7:0];
      q.push_back({a == 8'h3C || a == 8'h40 && (w || cap_list_enable), x});
      host.acc(w, a, d);
   endtask
   always @(negedge clk)
      if (cfg_ack === 1'b1)
         chk({cfg_hit, cfg_rdata}, q.pop_front());
   initial begin
      repeat (2) begin
         rst_n <= 0;
         repeat (2) @(posedge clk);
         rst_n <= 1;
         soft_rst <= ~soft_rst;
         {lat, gnt, ln} = 24'h340B00;
         wk = 1;
         op(0, 8'h3C, 0);
         op(1, 8'h3C, $random(seed));
         op(0, 8'h3C, 0);
         x = $random(seed);
         ee_lat_load <= 1;
         {ee_max_lat, ee_min_gnt} <= x[15:0];
         @(posedge clk);
         ee_lat_load <= 0;
         {lat, gnt} = x[15:0];
         op(0, 8'h3C, 0);
         for (i = 0; i < 4; i++) begin
            {aux_supply_sense_pin, cap_list_enable} <= i[1:0];
            @(posedge clk);
            op(0, 8'h40, 0);
         end
         for (i = 0; i < 2; i++) begin
            {ee_wake_load, pm_state_d3cold} <= {1'b1, i[0]};
            @(posedge clk);
            ee_wake_load <= 0;
            wk = !i[0];
            op(1, 8'h40, $random(seed));
            op(0, 8'h40, 0);
         end
         op(0, 8'h44, 0);
         @(posedge clk);
      end
      for (i = 0; i < 9 && q.size() > 0; i++) @(posedge clk);
      if (q.size() > 0) err_total++;
      end_of_test;
   end
   task end_of_test;
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
endmodule // pci_cfg_int_pm_capability_tb
bind pcp_cfg_regs pcp_sva chk_i (.*);
